// [pmic_mode_and_serial_target_tb.sv]
// Purpose: self-checking bench joining controller and target ends
// Assumes: 40 MHz clock, short fuse load count
// Notes: requests and responses are sampled on the falling clock edge
module pmic_mode_and_serial_target_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pms_pkg::*;
  localparam int unsigned OTPC = 2;
  localparam logic [7:0] OTPV = 8'h5c;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sup = 1'b0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic rsp_ready = 1'b1;
  logic [7:0] req_reg = 8'h00;
  logic [7:0] req_data = 8'h00;
  pms_speed_t speed = PMS_SPD_HS;
  logic req_ready, rsp_valid, rsp_nack, bias_on, ctrl_on, busy, wr_stb;
  logic [7:0] rsp_data, reg_en, wr_addr, wr_data;
  pms_mode_t mode;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int stb_n = 0;
  pms_bus_if bus();
  pms_target #(.OTP_CYCLES(OTPC)) pms_target_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_supply_ok(sup), .i_otp_byte(OTPV), .i_reg_en_mask(8'h03), .bus(bus), .o_mode(mode),
    .o_bias_on(bias_on), .o_ctrl_on(ctrl_on), .o_bus_busy(busy), .o_reg_en(reg_en),
    .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  pms_ctl pms_ctl_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_speed(speed),
    .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_read(req_read),
    .i_req_reg(req_reg), .i_req_data(req_data), .o_rsp_valid(rsp_valid),
    .i_rsp_ready(rsp_ready), .o_rsp_data(rsp_data), .o_rsp_nack(rsp_nack), .bus(bus));
  pms_bus_chk pms_bus_chk_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_supply_ok(sup),
    .scl(bus.scl), .sda(bus.sda), .sda_oe_n_ctl(bus.sda_oe_n_ctl),
    .sda_oe_n_tgt(bus.sda_oe_n_tgt));
  // ----------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------
  always #12.5 i_sys_clk = ~i_sys_clk;
  // every landed data byte gives one strobe
  always @(posedge i_sys_clk) if (wr_stb === 1'b1) stb_n <= stb_n + 1;
  // ceiling well above the slowest standard-rate write
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails = fails + 1;
      conclude();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request held until the edge at which ready is high
  task automatic push(input logic rd, input logic [7:0] r, input logic [7:0] d);
    @(posedge i_sys_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_reg <= r;
    req_data <= d;
    do @(negedge i_sys_clk); while (req_ready !== 1'b1);
    @(posedge i_sys_clk);
    req_valid <= 1'b0;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] r, input logic [7:0] d,
    output logic [7:0] q, output logic nk);
    push(rd, r, d);
    do @(negedge i_sys_clk); while (rsp_valid !== 1'b1);
    q = rsp_data;
    nk = rsp_nack;
    @(posedge i_sys_clk);
  endtask
  task automatic wait_mode(input pms_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 40) begin
      @(negedge i_sys_clk);
      n++;
    end
    cmp8({6'h0, mode}, {6'h0, m});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power();
    logic [7:0] q;
    logic nk;
    repeat (4) @(negedge i_sys_clk);
    cmp8({6'h0, mode}, {6'h0, PMS_MODE_SHUTDOWN});
    cmp8({6'h0, bias_on, ctrl_on}, 8'h00);
    @(posedge i_sys_clk);
    sup <= 1'b1;
    wait_mode(PMS_MODE_OTP);
    cmp8({7'h0, bias_on}, 8'h01);
    wait_mode(PMS_MODE_STANDBY);
    cmp8({6'h0, bias_on, ctrl_on}, 8'h03);
    cmp8(reg_en, 8'h00);
    xfer(1'b1, 8'h05, 8'h00, q, nk);
    cmp8(q, OTPV);
    $display("test power done");
  endtask
  task automatic t_speeds();
    logic [7:0] q;
    logic nk;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_sys_clk);
      speed <= pms_speed_t'(s);
      xfer(1'b0, 8'h04 + 8'(s), 8'ha0 + 8'(s), q, nk);
      cmp8({7'h0, nk}, 8'h00);
      cmp8(wr_addr, 8'h04 + 8'(s));
      cmp8(wr_data, 8'ha0 + 8'(s));
      cmp8({7'h0, busy}, 8'h00);
      // a standard-rate read would add over half again to the run time, so it is skipped
      if (s != 0) begin
        xfer(1'b1, 8'h04 + 8'(s), 8'h00, q, nk);
        cmp8(q, 8'ha0 + 8'(s));
        cmp8({7'h0, nk}, 8'h00);
      end
    end
    $display("test speeds done");
  endtask
  task automatic t_active();
    logic [7:0] q;
    logic nk;
    xfer(1'b0, 8'h00, 8'h01, q, nk);
    wait_mode(PMS_MODE_ACTIVE);
    cmp8(reg_en, 8'h01);
    repeat (2) begin
      xfer(1'b1, 8'h00, 8'h00, q, nk);
      cmp8(q, 8'h01);
    end
    xfer(1'b0, 8'h00, 8'hfc, q, nk);
    wait_mode(PMS_MODE_STANDBY);
    cmp8(reg_en, 8'h00);
    $display("test active done");
  endtask
  task automatic t_buffer();
    int n;
    @(posedge i_sys_clk);
    rsp_ready <= 1'b0;
    push(1'b0, 8'h08, 8'h11);
    repeat (100) @(negedge i_sys_clk);
    cmp8({7'h0, busy}, 8'h01);
    push(1'b0, 8'h09, 8'h22);
    fork
      push(1'b0, 8'h0a, 8'h33);
    join_none
    repeat (2500) @(negedge i_sys_clk);
    cmp8({6'h0, req_ready, rsp_valid}, 8'h01);
    @(posedge i_sys_clk);
    rsp_ready <= 1'b1;
    n = 0;
    repeat (3000) begin
      @(negedge i_sys_clk);
      if (rsp_valid === 1'b1) n++;
    end
    wait fork;
    cmp8(8'(n), 8'h03);
    cmp8(wr_data, 8'h33);
    $display("test buffer done");
  endtask
  task automatic t_loss();
    logic [7:0] q;
    logic nk;
    fork
      xfer(1'b0, 8'h06, 8'h77, q, nk);
      begin
        repeat (400) @(posedge i_sys_clk);
        sup <= 1'b0;
      end
    join
    cmp8({7'h0, nk}, 8'h01);
    cmp8({4'h0, mode, bias_on, ctrl_on}, {4'h0, PMS_MODE_SHUTDOWN, 2'h0});
    @(posedge i_sys_clk);
    sup <= 1'b1;
    wait_mode(PMS_MODE_STANDBY);
    xfer(1'b1, 8'h06, 8'h00, q, nk);
    cmp8(q, OTPV);
    cmp8(8'(stb_n), 8'h09);
    $display("test loss done");
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_power();
    t_speeds();
    t_active();
    t_buffer();
    t_loss();
    conclude();
  end
endmodule

// [pms_bus_chk.sv]
// Purpose: timing checks on the shared two-wire lines
// Assumes: one clock, bus lines oversampled by it
// Notes: helper counters track bit and byte position; restart counts as start
module pms_bus_chk (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_supply_ok, // supply above lockout
  input wire logic scl, // clock line
  input wire logic sda, // data line
  input wire logic sda_oe_n_ctl, // controller pulls data while low
  input wire logic sda_oe_n_tgt // target pulls data while low
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic scl_r, sda_r, busy_r, rd_r;
  logic [3:0] bit_r;
  logic [2:0] byte_r;
  wire rise = scl & ~scl_r;
  wire start = scl & scl_r & sda_r & ~sda;
  wire stop = scl & scl_r & ~sda_r & sda;
  // ----------------------------------------
  // line history and byte position
  // ----------------------------------------
  // reset to idle high so the first sample after reset is no false edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      busy_r <= start | (busy_r & ~stop);
    end
  end
  // bit index counts scl rises since start, wraps after the ninth pulse
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_r <= 4'h0;
      byte_r <= 3'h0;
      rd_r <= 1'b0;
    end else if (start) begin
      bit_r <= 4'h0;
      byte_r <= 3'h0;
    end else if (rise) begin
      bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      byte_r <= (bit_r == 4'h8) ? byte_r + 3'h1 : byte_r;
      rd_r <= (bit_r == 4'h7 && byte_r == 3'h0) ? sda : rd_r;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  tgt_pull_low_a: assert property ($fell(sda_oe_n_tgt) |-> !scl)
    else $error("target pulled data while clock high");
  start_by_ctl_a: assert property (start |-> !sda_oe_n_ctl)
    else $error("start not made by controller");
  stop_by_ctl_a: assert property (stop |-> sda_oe_n_ctl && sda_oe_n_tgt)
    else $error("stop not made by controller");
  free_no_pull_a: assert property (!busy_r |-> sda_oe_n_tgt)
    else $error("target pulls data on free bus");
  whole_bytes_a: assert property ((start || stop) && busy_r |-> bit_r == 4'h1)
    else $error("frame edge inside a byte");
  addr_ack_a: assert property (rise && bit_r == 4'h8 && byte_r == 3'h0 && i_supply_ok
    |-> !sda_oe_n_tgt && sda_oe_n_ctl)
    else $error("address byte not acknowledged");
  wr_ack_a: assert property (rise && bit_r == 4'h8 && !rd_r && byte_r inside {3'h1, 3'h2}
    && i_supply_ok |-> !sda_oe_n_tgt)
    else $error("write byte not acknowledged");
  rd_ctl_free_a: assert property (rise && rd_r && byte_r == 3'h1 |-> sda_oe_n_ctl)
    else $error("controller drives during read byte");
  low_supply_a: assert property (!$past(i_supply_ok) |-> sda_oe_n_tgt)
    else $error("target drives data without supply");
  restart_c: cover property (start && busy_r);
  rd_nack_c: cover property (rise && bit_r == 4'h8 && rd_r && byte_r == 3'h1 && sda);
  stop_c: cover property (stop);
endmodule

// [pms_bus_if.sv]
// Purpose: two-wire bus between controller and target, open-drain resolved here
// Assumes: pull-ups keep both lines high when nobody pulls
// Notes: enables are active low, a low enable pulls the line low
interface pms_bus_if;
  logic scl_oe_n_ctl; // controller pulls clock while low
  logic sda_oe_n_ctl; // controller pulls data while low
  logic sda_oe_n_tgt; // target pulls data while low
  logic scl;
  logic sda;
  assign scl = scl_oe_n_ctl;
  assign sda = sda_oe_n_ctl & sda_oe_n_tgt;
  modport target (input scl, input sda, output sda_oe_n_tgt);
  modport controller (input scl, input sda, output scl_oe_n_ctl, output sda_oe_n_ctl);
endinterface

// [pms_ctl.sv]
// Purpose: controller end that writes and reads target registers
// Assumes: single controller on the bus, no clock stretching
// Notes: speed grade picks the half-period divider
module pms_ctl
  import pms_pkg::*;
#(
  parameter logic [6:0] TADDR = pms_pkg::PMS_DEF_TADDR
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire pms_pkg::pms_speed_t i_speed, // bus speed grade
  input wire logic i_req_valid, // request offered
  output logic o_req_ready, // request taken
  input wire logic i_req_read, // 1 read, 0 write
  input wire logic [7:0] i_req_reg, // register address
  input wire logic [7:0] i_req_data, // write data
  output logic o_rsp_valid, // response present
  input wire logic i_rsp_ready, // response taken
  output logic [7:0] o_rsp_data, // read data
  output logic o_rsp_nack, // target did not acknowledge
  pms_bus_if.controller bus // two-wire bus
);
  import pms_pkg::*;

  typedef enum logic [2:0] {
    PMS_C_IDLE = 3'h0, PMS_C_START = 3'h1, PMS_C_BYTE = 3'h3,
    PMS_C_RSTART = 3'h2, PMS_C_STOP = 3'h6, PMS_C_DONE = 3'h7
  } pms_cst_t;

  pms_cst_t st_r;
  logic [15:0] div_r, half;
  logic tick, scl_r, sda_r, rd_r, nack_r;
  logic [2:0] byte_r;
  logic [3:0] bit_r;
  logic [1:0] ph_r;
  logic [7:0] tx, rx_r, reg_r, dat_r;
  logic [1:0] bq_cnt_r;
  logic [7:0] bq_dat_r [2];
  logic bq_nack_r [2];
  logic bq_wp_r, bq_rp_r;

  // -------------------------------------------------------------
  // rate divider: one-cycle enable per half-period step, four steps per bit
  // -------------------------------------------------------------
  always_comb begin
    case (i_speed)
      PMS_SPD_STD: half = 16'(PMS_HALF_STD);
      PMS_SPD_FAST: half = 16'(PMS_HALF_FAST);
      PMS_SPD_FPLUS: half = 16'(PMS_HALF_FPLUS);
      default: half = 16'(PMS_HALF_HS);
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) div_r <= 16'h0000;
    else if (tick) div_r <= 16'h0000;
    else div_r <= div_r + 16'h0001;
  end
  assign tick = (div_r >= half - 16'h0001);

  // byte sequence: addr(w), reg, [data] or [restart, addr(r), read]
  always_comb begin
    case (byte_r)
      3'h0: tx = {TADDR, PMS_DIR_WRITE};
      3'h1: tx = reg_r;
      3'h2: tx = rd_r ? {TADDR, PMS_DIR_READ} : dat_r;
      default: tx = 8'hff; // released while reading
    endcase
  end

  // -------------------------------------------------------------
  // bus sequencer; ph 0 clock low, ph 1 set data, ph 2 clock high, ph 3 sample
  // -------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= PMS_C_IDLE;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      byte_r <= 3'h0;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
      rx_r <= 8'h00;
      reg_r <= 8'h00;
      dat_r <= 8'h00;
    end else if (st_r == PMS_C_IDLE) begin
      if (i_req_valid && o_req_ready) begin
        st_r <= PMS_C_START;
        rd_r <= i_req_read;
        reg_r <= i_req_reg;
        dat_r <= i_req_data;
        byte_r <= 3'h0;
        nack_r <= 1'b0;
      end
    end else if (tick) begin
      case (st_r)
        PMS_C_START: begin
          sda_r <= 1'b0; // data falls while clock high
          st_r <= PMS_C_BYTE;
          bit_r <= 4'h0;
          ph_r <= 2'h0;
        end
        PMS_C_BYTE: begin
          if (ph_r == 2'h0) begin
            scl_r <= 1'b0;
            ph_r <= 2'h1;
          end else if (ph_r == 2'h1) begin
            // data moves only with clock low; msb first then released ack
            sda_r <= (bit_r < PMS_ACK_BIT) ? tx[3'(7 - bit_r)] : (byte_r == 3'h3 ? 1'b1 : 1'b1);
            if (bit_r == PMS_ACK_BIT && byte_r == 3'h3) sda_r <= 1'b1; // nack
            ph_r <= 2'h2;
          end else if (ph_r == 2'h2) begin
            scl_r <= 1'b1;
            ph_r <= 2'h3;
          end else begin
            if (bit_r < PMS_ACK_BIT) rx_r <= {rx_r[6:0], bus.sda};
            else if (byte_r != 3'h3 && bus.sda) nack_r <= 1'b1;
            ph_r <= 2'h0;
            if (bit_r != PMS_ACK_BIT) begin
              bit_r <= bit_r + 4'h1;
            end else begin
              bit_r <= 4'h0;
              if (byte_r != 3'h3 && bus.sda) st_r <= PMS_C_STOP;
              else if (byte_r == 3'h3 || (byte_r == 3'h2 && !rd_r)) st_r <= PMS_C_STOP;
              else if (byte_r == 3'h1 && rd_r) st_r <= PMS_C_RSTART;
              byte_r <= (byte_r == 3'h1 && rd_r) ? 3'h2 : byte_r + 3'h1;
            end
          end
        end
        PMS_C_RSTART: begin
          // clock low, raise data, raise clock, then start
          if (ph_r == 2'h0) begin
            scl_r <= 1'b0;
            ph_r <= 2'h1;
          end else if (ph_r == 2'h1) begin
            sda_r <= 1'b1;
            ph_r <= 2'h2;
          end else begin
            scl_r <= 1'b1;
            st_r <= PMS_C_START;
          end
        end
        PMS_C_STOP: begin
          if (ph_r == 2'h0) begin
            scl_r <= 1'b0;
            ph_r <= 2'h1;
          end else if (ph_r == 2'h1) begin
            sda_r <= 1'b0;
            ph_r <= 2'h2;
          end else if (ph_r == 2'h2) begin
            scl_r <= 1'b1;
            ph_r <= 2'h3;
          end else begin
            sda_r <= 1'b1; // data rises while clock high
            ph_r <= 2'h0;
            st_r <= PMS_C_DONE;
          end
        end
        PMS_C_DONE: if (bq_cnt_r != 2'h2) st_r <= PMS_C_IDLE;
        default: st_r <= PMS_C_IDLE;
      endcase
    end
  end

  assign o_req_ready = (st_r == PMS_C_IDLE);
  assign bus.scl_oe_n_ctl = scl_r;
  assign bus.sda_oe_n_ctl = sda_r;

  // -------------------------------------------------------------
  // two-entry response buffer; done waits while it is full
  // -------------------------------------------------------------
  logic bq_push, bq_pop;
  assign bq_push = tick && st_r == PMS_C_DONE && bq_cnt_r != 2'h2;
  assign bq_pop = o_rsp_valid && i_rsp_ready;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bq_cnt_r <= 2'h0;
      bq_wp_r <= 1'b0;
      bq_rp_r <= 1'b0;
      bq_dat_r[0] <= 8'h00;
      bq_dat_r[1] <= 8'h00;
      bq_nack_r[0] <= 1'b0;
      bq_nack_r[1] <= 1'b0;
    end else begin
      if (bq_push) begin
        bq_dat_r[bq_wp_r] <= rd_r ? rx_r : 8'h00;
        bq_nack_r[bq_wp_r] <= nack_r;
        bq_wp_r <= !bq_wp_r;
      end
      if (bq_pop) bq_rp_r <= !bq_rp_r;
      bq_cnt_r <= bq_cnt_r + {1'b0, bq_push} - {1'b0, bq_pop};
    end
  end
  assign o_rsp_valid = (bq_cnt_r != 2'h0);
  assign o_rsp_data = bq_dat_r[bq_rp_r];
  assign o_rsp_nack = bq_nack_r[bq_rp_r];
endmodule

// [pms_pkg.sv]
// Purpose: shared constants and types for the serial target and its controller end
// Assumes: one 40 MHz clock, both ends share it
// Notes: bus timing counts are derived from the half-period at the selected speed grade
package pms_pkg;
  localparam int unsigned PMS_CLK_HZ = 40_000_000;
  localparam logic [6:0] PMS_DEF_TADDR = 7'h60; // example target address
  localparam logic PMS_DIR_WRITE = 1'b0;
  localparam logic PMS_DIR_READ = 1'b1;
  localparam int unsigned PMS_BYTE_BITS = 8;
  localparam logic [3:0] PMS_ACK_BIT = 4'h8; // bit index of the ninth pulse
  // bus rates in hertz
  localparam int unsigned PMS_RATE_STD_HZ = 100_000;
  localparam int unsigned PMS_RATE_FAST_HZ = 400_000;
  localparam int unsigned PMS_RATE_FPLUS_HZ = 1_000_000;
  localparam int unsigned PMS_RATE_HS_HZ = 3_400_000;
  // half-period in clock cycles, rounded up so the bus never runs too fast
  localparam int unsigned PMS_HALF_STD = (PMS_CLK_HZ + 2*PMS_RATE_STD_HZ - 1) / (2*PMS_RATE_STD_HZ);
  localparam int unsigned PMS_HALF_FAST = (PMS_CLK_HZ + 2*PMS_RATE_FAST_HZ - 1) / (2*PMS_RATE_FAST_HZ);
  localparam int unsigned PMS_HALF_FPLUS =
    (PMS_CLK_HZ + 2*PMS_RATE_FPLUS_HZ - 1) / (2*PMS_RATE_FPLUS_HZ);
  localparam int unsigned PMS_HALF_HS = (PMS_CLK_HZ + 2*PMS_RATE_HS_HZ - 1) / (2*PMS_RATE_HS_HZ);
  localparam int unsigned PMS_OTP_CYCLES = 16; // cycles spent copying fuse bits
  localparam logic [7:0] PMS_REG_RST = 8'h00;

  typedef enum logic [1:0] {
    PMS_SPD_STD = 2'h0,
    PMS_SPD_FAST = 2'h1,
    PMS_SPD_FPLUS = 2'h2,
    PMS_SPD_HS = 2'h3
  } pms_speed_t;

  typedef enum logic [1:0] {
    PMS_MODE_SHUTDOWN = 2'h0,
    PMS_MODE_OTP = 2'h1,
    PMS_MODE_STANDBY = 2'h3,
    PMS_MODE_ACTIVE = 2'h2
  } pms_mode_t;
endpackage

// [pms_target.sv]
// Purpose: serial target port and operating mode sequencing of the power device
// Assumes: bus lines synchronous to i_sys_clk and slow enough to be oversampled
// Notes: register file is a plain array; regulators are represented by enable bits
//
// Overview of operation
// - below lockout, shutdown mode, everything off
// - above lockout, pass through fuse load mode
// - standby: regulators off, registers fully accessible
// - active when supplied and any regulator enabled
// - works at all four bus speed grades
// - data changes only while clock low
// - controller makes start and stop; target detects
// - busy after start, free after stop; restart equal
// - eight bits, MSB first, then acknowledge bit
// - target acknowledges each received byte on ninth pulse
// - controller not-acknowledges last read byte
// - supply lost mid transfer: stop driving data
// - first byte: seven-bit address plus direction bit
// - write: register address byte, then data
// - respond to configured seven-bit target address
// - write data auto-increments register index
// - reads never auto-increment
// - supply return: shutdown to standby via fuse load
module pms_target
  import pms_pkg::*;
#(
  parameter logic [6:0] TADDR = pms_pkg::PMS_DEF_TADDR,
  parameter int unsigned NREG = 16,
  parameter int unsigned OTP_CYCLES = pms_pkg::PMS_OTP_CYCLES
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_supply_ok, // main_supply_input above supply_lockout_threshold
  input wire logic [7:0] i_otp_byte, // fuse value copied into every register at load
  input wire logic [7:0] i_reg_en_mask, // bits of register 0 that enable regulators
  pms_bus_if.target bus, // two-wire bus
  output pms_pkg::pms_mode_t o_mode, // operating mode
  output logic o_bias_on, // reference and bias running
  output logic o_ctrl_on, // control circuitry running
  output logic o_bus_busy, // between start and stop
  output logic [7:0] o_reg_en, // regulator enables
  output logic o_wr_stb, // one-cycle register write strobe
  output logic [7:0] o_wr_addr, // written register address
  output logic [7:0] o_wr_data // written data
);
  import pms_pkg::*;
  localparam int unsigned AW = $clog2(NREG);

  typedef enum logic [2:0] {
    PMS_T_IDLE = 3'h0, PMS_T_ADDR = 3'h1, PMS_T_PTR = 3'h3, PMS_T_WDAT = 3'h2,
    PMS_T_RDAT = 3'h6, PMS_T_IGN = 3'h7
  } pms_tst_t;

  logic [7:0] regs_r [NREG];
  pms_mode_t mode_r;
  logic [15:0] otp_cnt_r;
  pms_tst_t st_r;
  logic scl_q_r, sda_q_r, busy_r, drv_r, ack_ph_r, rd_nack_r;
  logic [3:0] bit_r;
  logic [7:0] shf_r, ptr_r, tx_r;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  // -------------------------------------------------------------
  // mode sequencing
  // -------------------------------------------------------------
  // lockout wins over everything so a supply dip drops straight to shutdown
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= PMS_MODE_SHUTDOWN;
      otp_cnt_r <= 16'h0000;
    end else if (!i_supply_ok) begin
      mode_r <= PMS_MODE_SHUTDOWN;
      otp_cnt_r <= 16'h0000;
    end else begin
      case (mode_r)
        PMS_MODE_SHUTDOWN: mode_r <= PMS_MODE_OTP;
        PMS_MODE_OTP: begin
          otp_cnt_r <= otp_cnt_r + 16'h0001;
          if (otp_cnt_r >= 16'(OTP_CYCLES - 1)) mode_r <= PMS_MODE_STANDBY;
        end
        PMS_MODE_STANDBY: if (o_reg_en != 8'h00) mode_r <= PMS_MODE_ACTIVE;
        PMS_MODE_ACTIVE: if (o_reg_en == 8'h00) mode_r <= PMS_MODE_STANDBY;
        default: mode_r <= PMS_MODE_SHUTDOWN;
      endcase
    end
  end

  assign o_mode = mode_r;
  assign o_bias_on = (mode_r != PMS_MODE_SHUTDOWN);
  assign o_ctrl_on = (mode_r == PMS_MODE_STANDBY) || (mode_r == PMS_MODE_ACTIVE);
  // regulators only in standby/active; a nonzero value here moves standby to active on the next cycle
  assign o_reg_en = o_ctrl_on ? (regs_r[0] & i_reg_en_mask) : 8'h00;

  // -------------------------------------------------------------
  // bus edge detection
  // -------------------------------------------------------------
  // inputs are synchronous, so one register stage suffices for edges
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= bus.scl;
      sda_q_r <= bus.sda;
    end
  end

  // oversampling at 40 MHz keeps up with the high-speed grade
  assign start_ev = scl_q_r && bus.scl && sda_q_r && !bus.sda;
  assign stop_ev = scl_q_r && bus.scl && !sda_q_r && bus.sda;
  assign scl_rise = !scl_q_r && bus.scl;
  assign scl_fall = scl_q_r && !bus.scl;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) busy_r <= 1'b0;
    else if (start_ev) busy_r <= 1'b1;
    else if (stop_ev) busy_r <= 1'b0;
  end
  assign o_bus_busy = busy_r;

  // -------------------------------------------------------------
  // byte engine
  // -------------------------------------------------------------
  // a restart re-enters the address phase just like a start
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= PMS_T_IDLE;
      bit_r <= 4'h0;
      shf_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_ph_r <= 1'b0;
      rd_nack_r <= 1'b0;
    end else if (start_ev) begin
      st_r <= PMS_T_ADDR;
      bit_r <= 4'h0;
      ack_ph_r <= 1'b0;
    end else if (stop_ev || !o_ctrl_on) begin
      st_r <= PMS_T_IDLE;
      ack_ph_r <= 1'b0;
    end else if (scl_rise && st_r != PMS_T_IDLE && st_r != PMS_T_IGN) begin
      if (bit_r < PMS_ACK_BIT) begin
        shf_r <= {shf_r[6:0], bus.sda}; // msb first
        bit_r <= bit_r + 4'h1;
      end else begin
        rd_nack_r <= bus.sda; // high ends the read
      end
    end else if (scl_fall && st_r != PMS_T_IDLE && st_r != PMS_T_IGN) begin
      if (bit_r == PMS_ACK_BIT && !ack_ph_r) begin
        ack_ph_r <= 1'b1; // ninth pulse begins
        case (st_r)
          PMS_T_ADDR:
            if (shf_r[7:1] != TADDR) st_r <= PMS_T_IGN;
          default: ;
        endcase
      end else if (ack_ph_r) begin
        ack_ph_r <= 1'b0;
        bit_r <= 4'h0;
        case (st_r)
          PMS_T_ADDR: st_r <= (shf_r[0] == PMS_DIR_READ) ? PMS_T_RDAT : PMS_T_PTR;
          PMS_T_PTR: begin
            ptr_r <= shf_r;
            st_r <= PMS_T_WDAT;
          end
          PMS_T_WDAT: ptr_r <= ptr_r + 8'h01;
          PMS_T_RDAT: if (rd_nack_r) st_r <= PMS_T_IGN; // no increment
          default: st_r <= PMS_T_IDLE;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // register file and write strobe
  // -------------------------------------------------------------
  logic wr_now;
  assign wr_now = scl_fall && ack_ph_r && st_r == PMS_T_WDAT && o_ctrl_on;

  // the whole file loads from fuses during the load step
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NREG; i++) regs_r[i] <= PMS_REG_RST;
    end else if (mode_r == PMS_MODE_SHUTDOWN) begin
      for (int i = 0; i < NREG; i++) regs_r[i] <= PMS_REG_RST;
    end else if (mode_r == PMS_MODE_OTP) begin
      for (int i = 0; i < NREG; i++) regs_r[i] <= i_otp_byte;
    end else if (wr_now && ptr_r < 8'(NREG)) begin
      regs_r[ptr_r[AW-1:0]] <= shf_r;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_stb <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 8'h00;
    end else begin
      o_wr_stb <= wr_now;
      if (wr_now) begin
        o_wr_addr <= ptr_r;
        o_wr_data <= shf_r;
      end
    end
  end

  // -------------------------------------------------------------
  // data line drive
  // -------------------------------------------------------------
  // drive changes on a falling clock, and clears at once on supply loss, start or stop
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      drv_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (!i_supply_ok || start_ev || stop_ev) begin
      drv_r <= 1'b0;
    end else if (scl_fall) begin
      if (bit_r == PMS_ACK_BIT && !ack_ph_r && st_r != PMS_T_IDLE && st_r != PMS_T_IGN &&
          st_r != PMS_T_RDAT && !(st_r == PMS_T_ADDR && shf_r[7:1] != TADDR)) begin
        drv_r <= 1'b1; // acknowledge
      end else if (ack_ph_r && st_r == PMS_T_ADDR && shf_r[0] == PMS_DIR_READ) begin
        tx_r <= (ptr_r < 8'(NREG)) ? regs_r[ptr_r[AW-1:0]] : 8'h00;
        drv_r <= !((ptr_r < 8'(NREG)) ? regs_r[ptr_r[AW-1:0]][7] : 1'b0);
      end else if (st_r == PMS_T_RDAT && !ack_ph_r && bit_r < PMS_ACK_BIT) begin
        drv_r <= !tx_r[3'(4'h7 - bit_r)]; // next bit, msb went out at the ack fall
      end else begin
        drv_r <= 1'b0; // release for controller acknowledge
      end
    end
  end

  // supply loss cuts the drive at once, without waiting for a clock fall
  assign bus.sda_oe_n_tgt = !(drv_r && i_supply_ok);
endmodule
